// ### src/pisc_pkg.sv
// package for the pll input select configuration block
package pisc_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] PISC_ADDR_RUN_BYP  = 8'h00;
  localparam logic [7:0] PISC_ADDR_PRIO     = 8'h01;
  localparam logic [7:0] PISC_ADDR_BW_RATE  = 8'h02;
  localparam logic [7:0] PISC_ADDR_CAL_SQ   = 8'h03;
  localparam logic [7:0] PISC_ADDR_SEL_METH = 8'h04;

  // ==========================================================================
  // reset values
  localparam logic [7:0] PISC_RST_RUN_BYP  = 8'h14;
  localparam logic [7:0] PISC_RST_PRIO     = 8'hE4;
  localparam logic [7:0] PISC_RST_BW_RATE  = 8'h42;
  localparam logic [7:0] PISC_RST_CAL_SQ   = 8'h05;
  localparam logic [7:0] PISC_RST_SEL_METH = 8'h12;

  // ==========================================================================
  // writable bit masks
  localparam logic [7:0] PISC_WMSK_RUN_BYP  = 8'h62;
  localparam logic [7:0] PISC_WMSK_PRIO     = 8'h0F;
  localparam logic [7:0] PISC_WMSK_BW_RATE  = 8'hFF;
  localparam logic [7:0] PISC_WMSK_CAL_SQ   = 8'h10;
  localparam logic [7:0] PISC_WMSK_SEL_METH = 8'hC0;

  // ==========================================================================
  // field positions
  localparam int PISC_BIT_FREE_RUN = 6;
  localparam int PISC_BIT_UNSQ     = 5;
  localparam int PISC_BIT_BYPASS   = 1;
  localparam int PISC_BIT_CAL_SQ   = 4;
  localparam int PISC_LSB_PRIO2    = 2;
  localparam int PISC_LSB_PRIO1    = 0;
  localparam int PISC_LSB_BW       = 4;
  localparam int PISC_LSB_RATE     = 0;
  localparam int PISC_LSB_METH     = 6;

  // ==========================================================================
  // codes
  localparam logic [1:0] PISC_IN_ONE      = 2'h0;
  localparam logic [1:0] PISC_IN_TWO      = 2'h1;
  localparam logic [3:0] PISC_RATE_LOW    = 4'h5;
  localparam logic [3:0] PISC_RATE_HIGH   = 4'h6;

  typedef enum logic [1:0] {
    PISC_METH_MANUAL  = 2'b00,
    PISC_METH_AUTO_NR = 2'b01,
    PISC_METH_AUTO_RV = 2'b10,
    PISC_METH_RSVD    = 2'b11
  } pisc_meth_t;

  typedef enum logic [1:0] {
    PISC_CAL_IDLE = 2'b00,
    PISC_CAL_BUSY = 2'b01,
    PISC_CAL_DONE = 2'b10
  } pisc_cal_t;

endpackage

// ### src/pisc_reg8.sv
// one 8-bit register with write mask and reset value
`timescale 1ns/100ps
module pisc_reg8 #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WR_MSK  = 8'hFF
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] q
);

  logic [7:0] val_ff;
  logic [7:0] nxt_val;

  // reserved bits keep reset value
  assign nxt_val = wr_en ? ((wr_data & WR_MSK) | (RST_VAL & ~WR_MSK)) : val_ff;
  assign q       = val_ff;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      val_ff <= RST_VAL;
    end else begin
      val_ff <= nxt_val;
    end
  end

endmodule // pisc_reg8

// ### src/pisc_top.sv
// configuration registers and output steering for one pll
`timescale 1ns/100ps
// Operation
// - free-run bit routes reference oscillator onto input two
// - unsquelch override drives outputs even if calibration incomplete or failed
// - override clear: outputs squelched until a calibration completes successfully
// - bypass bit connects selected input straight to output buffers
// - second priority input from bits 3:2; 00 one, 01 two
// - first priority input from bits 1:0; 00 one, 01 two
// - loop bandwidth bits 7:4, applied only at next calibration
// - reference rate code 0101 or 0110 valid, others reserved
// - selection method: manual, automatic non-revertive, automatic revertive
// - calibration squelch bit disables outputs during calibration
module pisc_top
  import pisc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       cal_start,
  input  wire logic       cal_finish,
  input  wire logic       cal_ok,
  input  wire logic [1:0] active_input,
  output logic            osc_to_input_two,
  output logic            pll_bypass,
  output logic [1:0]      bypass_input,
  output logic            output_enable,
  output logic [1:0]      first_priority_input,
  output logic [1:0]      second_priority_input,
  output logic            priority_valid,
  output logic [3:0]      loop_bandwidth_select,
  output logic [3:0]      ref_rate_code,
  output logic            ref_rate_valid,
  output logic [1:0]      selection_method,
  output logic            auto_select,
  output logic            auto_revertive,
  output logic            cal_busy,
  output logic            cal_done
);

  // ==========================================================================
  // register file
  logic [7:0] r0_q;
  logic [7:0] r1_q;
  logic [7:0] r2_q;
  logic [7:0] r3_q;
  logic [7:0] r4_q;
  logic [7:0] rdata_mux;

  wire wr0 = reg_wr && (reg_addr == PISC_ADDR_RUN_BYP);
  wire wr1 = reg_wr && (reg_addr == PISC_ADDR_PRIO);
  wire wr2 = reg_wr && (reg_addr == PISC_ADDR_BW_RATE);
  wire wr3 = reg_wr && (reg_addr == PISC_ADDR_CAL_SQ);
  wire wr4 = reg_wr && (reg_addr == PISC_ADDR_SEL_METH);

  pisc_reg8 #(.RST_VAL(PISC_RST_RUN_BYP), .WR_MSK(PISC_WMSK_RUN_BYP)) u_r0 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (wr0),
    .wr_data (reg_wdata),
    .q       (r0_q)
  );
  pisc_reg8 #(.RST_VAL(PISC_RST_PRIO), .WR_MSK(PISC_WMSK_PRIO)) u_r1 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (wr1),
    .wr_data (reg_wdata),
    .q       (r1_q)
  );
  pisc_reg8 #(.RST_VAL(PISC_RST_BW_RATE), .WR_MSK(PISC_WMSK_BW_RATE)) u_r2 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (wr2),
    .wr_data (reg_wdata),
    .q       (r2_q)
  );
  pisc_reg8 #(.RST_VAL(PISC_RST_CAL_SQ), .WR_MSK(PISC_WMSK_CAL_SQ)) u_r3 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (wr3),
    .wr_data (reg_wdata),
    .q       (r3_q)
  );
  pisc_reg8 #(.RST_VAL(PISC_RST_SEL_METH), .WR_MSK(PISC_WMSK_SEL_METH)) u_r4 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (wr4),
    .wr_data (reg_wdata),
    .q       (r4_q)
  );

  // ==========================================================================
  // read mux, registered
  assign rdata_mux = (reg_addr == PISC_ADDR_RUN_BYP)  ? r0_q :
                     (reg_addr == PISC_ADDR_PRIO)     ? r1_q :
                     (reg_addr == PISC_ADDR_BW_RATE)  ? r2_q :
                     (reg_addr == PISC_ADDR_CAL_SQ)   ? r3_q :
                     (reg_addr == PISC_ADDR_SEL_METH) ? r4_q : 8'h00;

  logic [7:0] rdata_ff;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= rdata_mux;
    end
  end
  assign reg_rdata = rdata_ff;

  // ==========================================================================
  // calibration tracker
  pisc_cal_t cal_st_ff;
  pisc_cal_t nxt_cal_st;
  logic      cal_good_ff;
  logic      prev_good_ff;
  logic [3:0] bw_active_ff;

  always_comb begin
    nxt_cal_st = cal_st_ff;
    case (cal_st_ff)
      PISC_CAL_IDLE: begin
        if (cal_start) begin
          nxt_cal_st = PISC_CAL_BUSY;
        end
      end
      PISC_CAL_BUSY: begin
        if (cal_finish) begin
          nxt_cal_st = PISC_CAL_DONE;
        end
      end
      PISC_CAL_DONE: begin
        if (cal_start) begin
          nxt_cal_st = PISC_CAL_BUSY;
        end
      end
      default: begin
        nxt_cal_st = PISC_CAL_IDLE;
      end
    endcase
  end

  wire cal_launch = cal_start && (cal_st_ff != PISC_CAL_BUSY);
  wire cal_end    = cal_finish && (cal_st_ff == PISC_CAL_BUSY);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cal_st_ff <= PISC_CAL_IDLE;
    end else begin
      cal_st_ff <= nxt_cal_st;
    end
  end

  // bandwidth in effect, changed only at calibration launch
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bw_active_ff <= PISC_RST_BW_RATE[PISC_LSB_BW +: 4];
    end else if (cal_launch) begin
      bw_active_ff <= r2_q[PISC_LSB_BW +: 4];
    end
  end

  // last result, and the result in force before this calibration
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cal_good_ff  <= 1'b0;
      prev_good_ff <= 1'b0;
    end else if (cal_launch) begin
      cal_good_ff  <= 1'b0;
      prev_good_ff <= cal_good_ff;
    end else if (cal_end) begin
      cal_good_ff <= cal_ok;
    end
  end

  assign cal_busy = (cal_st_ff == PISC_CAL_BUSY);
  assign cal_done = cal_good_ff;

  // ==========================================================================
  // output steering
  wire unsq_ovr = r0_q[PISC_BIT_UNSQ];
  wire sq_cal   = r3_q[PISC_BIT_CAL_SQ];

  assign osc_to_input_two = r0_q[PISC_BIT_FREE_RUN];
  assign pll_bypass       = r0_q[PISC_BIT_BYPASS];
  assign bypass_input     = r0_q[PISC_BIT_BYPASS] ? active_input : 2'h0;


  // ==========================================================================
  // squelch decision
  // during a calibration the outputs run only if the one before succeeded
  wire cal_quiet_ok = prev_good_ff && !sq_cal;
  wire cal_gate     = cal_busy ? cal_quiet_ok : cal_good_ff;
  // override wins over every squelch
  assign output_enable = unsq_ovr || cal_gate;

  // ==========================================================================
  // selection fields
  assign first_priority_input  = r1_q[PISC_LSB_PRIO1 +: 2];
  assign second_priority_input = r1_q[PISC_LSB_PRIO2 +: 2];
  wire prio1_ok = (r1_q[PISC_LSB_PRIO1 + 1] == 1'b0);
  wire prio2_ok = (r1_q[PISC_LSB_PRIO2 + 1] == 1'b0);
  assign priority_valid = prio1_ok && prio2_ok;

  assign loop_bandwidth_select = bw_active_ff;
  assign ref_rate_code         = r2_q[PISC_LSB_RATE +: 4];
  assign ref_rate_valid = (ref_rate_code == PISC_RATE_LOW)
                       || (ref_rate_code == PISC_RATE_HIGH);

  assign selection_method = r4_q[PISC_LSB_METH +: 2];
  assign auto_select    = (selection_method == PISC_METH_AUTO_NR)
                       || (selection_method == PISC_METH_AUTO_RV);
  assign auto_revertive = (selection_method == PISC_METH_AUTO_RV);

endmodule // pisc_top

// ### tb/pisc_top_assertions.sv
// checker for the pll input select configuration block
`timescale 1ns/100ps
module pisc_chk
  import pisc_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       cal_start,
  input wire logic       cal_busy,
  input wire logic       cal_done,
  input wire logic [1:0] active_input,
  input wire logic       osc_to_input_two,
  input wire logic       pll_bypass,
  input wire logic [1:0] bypass_input,
  input wire logic       output_enable,
  input wire logic [1:0] first_priority_input,
  input wire logic [1:0] second_priority_input,
  input wire logic [3:0] loop_bandwidth_select,
  input wire logic [3:0] ref_rate_code,
  input wire logic       ref_rate_valid
);
  // ====
  // shadow copies of written fields and of the result before a calibration
  logic       ovr_ff;
  logic [3:0] bw_ff;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) ovr_ff <= 1'b0;
    else if (reg_wr && reg_addr == PISC_ADDR_RUN_BYP) ovr_ff <= reg_wdata[5];
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) bw_ff <= PISC_RST_BW_RATE[7:4];
    else if (reg_wr && reg_addr == PISC_ADDR_BW_RATE) bw_ff <= reg_wdata[7:4];
  end
  logic       sq_ff;
  logic       prev_ok_ff;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) sq_ff <= PISC_RST_CAL_SQ[PISC_BIT_CAL_SQ];
    else if (reg_wr && reg_addr == PISC_ADDR_CAL_SQ) sq_ff <= reg_wdata[PISC_BIT_CAL_SQ];
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) prev_ok_ff <= 1'b0;
    else if (cal_start && !cal_busy) prev_ok_ff <= cal_done;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ====
  // properties
  run_write_a: assert property ($past(rst_n) && $past(reg_wr) && $past(reg_addr) == 8'h00 |->
    osc_to_input_two == $past(reg_wdata[6]) && pll_bypass == $past(reg_wdata[1])) else $error("run reg write");
  bypass_route_a: assert property (bypass_input == (pll_bypass ? active_input : 2'h0))
    else $error("bypass route");
  override_on_a: assert property (ovr_ff |-> output_enable) else $error("override not on");
  squelch_hold_a: assert property (!ovr_ff && !cal_done && !(cal_busy && prev_ok_ff && !sq_ff) |-> !output_enable)
    else $error("outputs before cal");
  cal_enable_a: assert property (cal_done && !cal_busy |-> output_enable) else $error("outputs off");
  cal_squelch_a: assert property (cal_busy && sq_ff && !ovr_ff |-> !output_enable)
    else $error("outputs during cal");
  cal_keep_on_a: assert property (cal_busy && prev_ok_ff && !sq_ff |-> output_enable)
    else $error("outputs squelched during cal");
  prio_write_a: assert property ($past(rst_n) && $past(reg_wr) && $past(reg_addr) == 8'h01 |->
    first_priority_input == $past(reg_wdata[1:0]) && second_priority_input == $past(reg_wdata[3:2]))
    else $error("priority write");
  bw_latch_a: assert property ($past(rst_n) |-> loop_bandwidth_select ==
    ($past(cal_start) && !$past(cal_busy) ? $past(bw_ff) : $past(loop_bandwidth_select))) else $error("bandwidth");
  rate_valid_a: assert property (ref_rate_valid == (ref_rate_code inside {4'h5, 4'h6}))
    else $error("rate valid");
endmodule // pisc_chk

bind pisc_top pisc_chk u_chk (.clk_sys, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .cal_start, .cal_busy,
  .cal_done, .active_input, .osc_to_input_two, .pll_bypass, .bypass_input, .output_enable,
  .first_priority_input, .second_priority_input, .loop_bandwidth_select, .ref_rate_code, .ref_rate_valid);

// ### tb/pll_input_select_config_tb_top.sv
// self-checking bench for the pll input select configuration block
`timescale 1ns/100ps
module pll_input_select_config_tb_top
  import pisc_pkg::*;
;
  logic       clk_sys, rst_n, reg_wr, cal_start, cal_finish, cal_ok, rd_req;
  logic       osc_to_input_two, pll_bypass, output_enable, cal_busy, cal_done;
  logic       priority_valid, ref_rate_valid, auto_select, auto_revertive;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] active_input, bypass_input, first_priority_input, second_priority_input, selection_method;
  logic [3:0] loop_bandwidth_select, ref_rate_code;
  logic [31:0] rnd = 32'h725B;
  logic [7:0] exp_q[$];
  logic [7:0] rst_v[5] = '{8'h14, 8'hE4, 8'h42, 8'h05, 8'h12};
  logic [7:0] msk_v[5] = '{8'h62, 8'h0F, 8'hFF, 8'h10, 8'hC0};
  int         errors = 0, n_tests = 0, cyc = 0, a;
  pisc_top dut (.clk_sys, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .cal_start, .cal_finish,
    .cal_ok, .active_input, .osc_to_input_two, .pll_bypass, .bypass_input, .output_enable,
    .first_priority_input, .second_priority_input, .priority_valid, .loop_bandwidth_select,
    .ref_rate_code, .ref_rate_valid, .selection_method, .auto_select, .auto_revertive,
    .cal_busy, .cal_done);
  // ====
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = ad;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(negedge clk_sys);
    reg_addr = ad;
    rd_req = 1'b1;
    exp_q.push_back(e);
    @(negedge clk_sys);
    rd_req = 1'b0;
  endtask
  task automatic cal(input logic ok, input logic ob);
    @(negedge clk_sys);
    cal_start = 1'b1;
    @(negedge clk_sys);
    cal_start = 1'b0;
    chk({7'h0, cal_busy}, 8'h01);
    chk({7'h0, output_enable}, {7'h0, ob});
    cal_finish = 1'b1;
    cal_ok = ok;
    @(negedge clk_sys);
    cal_finish = 1'b0;
    chk({7'h0, cal_done}, {7'h0, ok});
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ====
  // clock, monitor, timeout
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (rd_req) begin
    #1;
    chk(reg_rdata, exp_q.pop_front());
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      wrap_up();
    end
  end
  // ====
  // main sequence
  initial begin
    {reg_wr, reg_addr, reg_wdata, cal_start, cal_finish, cal_ok, rd_req, active_input} = '0;
    rst_n = 1'b0;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    for (a = 0; a < 5; a++) rd(8'(a), rst_v[a]);
    rd(8'h05, 8'h00);
    chk({7'h0, output_enable}, 8'h00);
    $display("end test reset values");
    repeat (60) begin
      rnd = lfsr(rnd);
      a = rnd[10:8] % 5;
      active_input = {1'b0, rnd[12]};
      wr(8'(a), rnd[7:0]);
      rd(8'(a), (rst_v[a] & ~msk_v[a]) | (rnd[7:0] & msk_v[a]));
      if (a == 0) begin
        chk({7'h0, osc_to_input_two}, {7'h0, rnd[6]});
        chk({7'h0, pll_bypass}, {7'h0, rnd[1]});
        chk({6'h0, bypass_input}, rnd[1] ? {6'h0, active_input} : 8'h00);
      end
      if (a == 1) begin
        chk({6'h0, first_priority_input}, {6'h0, rnd[1:0]});
        chk({6'h0, second_priority_input}, {6'h0, rnd[3:2]});
        chk({7'h0, priority_valid}, {7'h0, (!rnd[1] && !rnd[3])});
      end
      if (a == 2) begin
        chk({4'h0, ref_rate_code}, {4'h0, rnd[3:0]});
        chk({7'h0, ref_rate_valid}, {7'h0, (rnd[3:0] inside {PISC_RATE_LOW, PISC_RATE_HIGH})});
      end
      if (a == 4) begin
        chk({6'h0, selection_method}, {6'h0, rnd[7:6]});
        chk({7'h0, auto_select}, {7'h0, (rnd[7:6] == 2'b01 || rnd[7:6] == 2'b10)});
        chk({7'h0, auto_revertive}, {7'h0, (rnd[7:6] == 2'b10)});
      end
    end
    $display("end test register access");
    wr(8'h00, 8'h00);
    wr(8'h03, 8'h10);
    wr(8'h02, 8'hA5);
    chk({4'h0, loop_bandwidth_select}, 8'h04);
    chk({7'h0, ref_rate_valid}, 8'h01);
    cal(1'b1, 1'b0);
    chk({4'h0, loop_bandwidth_select}, 8'h0A);
    chk({7'h0, output_enable}, 8'h01);
    wr(8'h03, 8'h00);
    cal(1'b1, 1'b1);
    wr(8'h03, 8'h10);
    cal(1'b0, 1'b0);
    chk({7'h0, output_enable}, 8'h00);
    wr(8'h00, 8'h20);
    chk({7'h0, output_enable}, 8'h01);
    cal(1'b0, 1'b1);
    $display("end test calibration");
    @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    chk({4'h0, loop_bandwidth_select}, {4'h0, PISC_RST_BW_RATE[7:4]});
    chk({7'h0, output_enable}, 8'h00);
    rd(PISC_ADDR_RUN_BYP, PISC_RST_RUN_BYP);
    $display("end test mid-run reset");
    wrap_up();
  end
endmodule // pll_input_select_config_tb_top
